// *** inc/gx_pkg.sv ***
// Purpose: Shared constants and types for the 20-bit port expander core.
// Assumes: Registers are eight bits wide, ten of them, addressed 0 to 9.
// Notes: Reset values are loaded while the reset pin is held low.
package gx_pkg;
  localparam int PORTS = 20;
  localparam int LOW_PORTS = 8;
  localparam int REG_COUNT = 10;

  localparam logic [3:0] ADDR_DATA_LO = 4'h0;
  localparam logic [3:0] ADDR_DATA_MID = 4'h1;
  localparam logic [3:0] ADDR_DATA_HI = 4'h2;
  localparam logic [3:0] ADDR_MASK_LO = 4'h3;
  localparam logic [3:0] ADDR_MASK_HI = 4'h5;
  localparam logic [3:0] ADDR_DIR_LO = 4'h6;
  localparam logic [3:0] ADDR_DIR_HI = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'h9;
  localparam logic [3:0] ADDR_FIRST = 4'h0;
  localparam logic [3:0] ADDR_LAST = 4'h9;

  // Writable bits per register; the rest read as zero
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_NIBBLE = 8'h0F;
  localparam logic [7:0] MASK_CTRL = 8'h07;

  // Control register fields
  localparam int CTRL_STYLE_LO = 0;
  localparam int CTRL_STYLE_HI = 1;
  localparam int CTRL_IRQ_POL = 2;

  localparam logic [9:0][7:0] REG_RESET = {
    8'h03, 8'h0F, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h0F, 8'hFF, 8'hFF
  };

  // Seven-bit slave addresses picked by the address select pin
  localparam logic [6:0] SLAVE_ADDR_PIN_LO = 7'h08;
  localparam logic [6:0] SLAVE_ADDR_PIN_HI = 7'h0F;

  typedef enum logic [2:0] {
    GX_IDLE,
    GX_SLAVE,
    GX_REGADDR,
    GX_WRITE,
    GX_READ,
    GX_WAIT
  } gx_state_e;
endpackage

// *** rtl/gx_sync.sv ***
// Purpose: Two-stage synchroniser for pin levels.
// Assumes: Inputs are asynchronous to i_clock.
// Notes: First stage feeds only the second stage.
`timescale 1ns/10ps
module gx_sync
  import gx_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } gx_sync_s;

  gx_sync_s st_r;
  gx_sync_s st_nxt;

  always_comb
  begin
    st_nxt.meta = i_async;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= {INIT, INIT};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.stable;
endmodule

// *** rtl/gx_port_drive.sv ***
// Purpose: Per-port output and enable from data, direction and drive style.
// Assumes: Style 1 means pull-up mode, style 0 means direction control.
// Notes: Outputs are registered; enable high means the pin is driven.
`timescale 1ns/10ps
module gx_port_drive
  import gx_pkg::*;
#(
  parameter int WIDTH = PORTS,
  parameter int LOW_WIDTH = LOW_PORTS
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic [WIDTH-1:0] i_dir,
  input wire logic i_style_lo,
  input wire logic i_style_hi,
  output logic [WIDTH-1:0] o_out,
  output logic [WIDTH-1:0] o_oe
);
  typedef struct packed {
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] oe;
  } gx_drive_s;

  gx_drive_s st_r;
  gx_drive_s st_nxt;

  for (genvar b = 0; b < WIDTH; b++)
  begin : g_bit
    logic style;
    assign style = (b < LOW_WIDTH) ? i_style_lo : i_style_hi;
    always_comb
    begin
      if (style)
      begin
        // Pull-up mode: only ever drive low
        st_nxt.out[b] = 1'b0;
        st_nxt.oe[b] = ~i_data[b];
      end
      else
      begin
        st_nxt.out[b] = i_data[b];
        st_nxt.oe[b] = ~i_dir[b];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_out = st_r.out;
  assign o_oe = st_r.oe;
endmodule

// *** rtl/gx_core.sv ***
// Purpose: Register file and port control of a 20-bit expander behind a
//   byte-level 2-wire slave engine.
// Assumes: Engine runs on i_clock and delivers whole bytes, ack ends, start
//   and stop as one-cycle pulses.
// Notes: Register writes land only at the end of their acknowledge.
// Contract
// - All ports start as released inputs
// - Mask bit 1 suppresses that port's interrupt
// - Write byte applied only after its acknowledge
// - Pull-up mode: 0 drives low, 1 releases
// - Style 0: direction register decides port mode
// - Direction 0 drives data, 1 is input
// - Already-output ports show new data after ack
// - Read address captures pin levels into data
// - Read byte held stable between acknowledges
// - Interrupt follows unmasked transitions, refreshed per ack
// - Polarity bit 1 makes interrupt active low
// - Register address above 09h becomes 00h
// - Pointer wraps from 09h to 00h
// - Reset pin low loads initial values
// - Top register nibble ignored, reads zero
// - Control bits 0/1 pick group drive style
// - Broken access discards byte, awaits new start
// - Slave address chosen by address select pin
// - Write: register address, then auto-increment data
// - Read continues after last accessed address
`timescale 1ns/10ps
module gx_core
  import gx_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_active_low_reset_pin_n,
  input wire logic i_addr_sel,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_ack_done,
  input wire logic i_master_ack,
  input wire logic [PORTS-1:0] i_port_in,
  output logic o_ack,
  output logic o_read_mode,
  output logic [7:0] o_tx_byte,
  output logic [PORTS-1:0] o_port_out,
  output logic [PORTS-1:0] o_port_oe,
  output logic o_irq
);
  typedef struct packed {
    gx_state_e state;
    logic [3:0] ptr;
    logic rd;
    logic ack;
    logic [7:0] wdata;
    logic wpend;
    logic [7:0] tx;
    logic pend_q;
    logic irq;
    logic [REG_COUNT-1:0][7:0] regs;
  } gx_core_s;

  gx_core_s st_r;
  gx_core_s st_nxt;

  logic rst_pin_n_s;
  logic addr_sel_s;
  logic [PORTS-1:0] pins_s;
  logic [PORTS-1:0] data_v;
  logic [PORTS-1:0] mask_v;
  logic [PORTS-1:0] dir_v;
  logic [6:0] my_addr;
  logic pending;

  // Reset pin and address strap are pins, so both are synchronised
  gx_sync #(.WIDTH(2), .INIT(2'b00)) u_sync_ctl (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async({i_active_low_reset_pin_n, i_addr_sel}),
    .o_sync({rst_pin_n_s, addr_sel_s})
  );

  gx_sync #(.WIDTH(PORTS), .INIT('1)) u_sync_pins (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(i_port_in),
    .o_sync(pins_s)
  );

  assign data_v = {st_r.regs[ADDR_DATA_HI][3:0], st_r.regs[ADDR_DATA_MID],
                   st_r.regs[ADDR_DATA_LO]};
  assign mask_v = {st_r.regs[ADDR_MASK_HI][3:0], st_r.regs[ADDR_MASK_HI - 4'h1],
                   st_r.regs[ADDR_MASK_LO]};
  assign dir_v = {st_r.regs[ADDR_DIR_HI][3:0], st_r.regs[ADDR_DIR_HI - 4'h1],
                  st_r.regs[ADDR_DIR_LO]};
  assign my_addr = addr_sel_s ? SLAVE_ADDR_PIN_HI : SLAVE_ADDR_PIN_LO;

  // A pin that differs from its last captured value is a transition
  assign pending = |((pins_s ^ data_v) & ~mask_v);

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = (p >= ADDR_LAST) ? ADDR_FIRST : p + 4'h1;
  endfunction

  function automatic logic [7:0] wr_mask(input logic [3:0] a);
    unique case (a)
      ADDR_DATA_HI, ADDR_MASK_HI, ADDR_DIR_HI: wr_mask = MASK_NIBBLE;
      ADDR_CTRL: wr_mask = MASK_CTRL;
      default: wr_mask = MASK_FULL;
    endcase
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pend_q = pending;
    // Refresh on every ack, and raise early on a new transition
    if (i_ack_done || (pending && !st_r.pend_q))
    begin
      st_nxt.irq = pending;
    end
    unique case (st_r.state)
      GX_IDLE, GX_WAIT:
      begin
        st_nxt.ack = 1'b0;
      end
      GX_SLAVE:
      begin
        if (i_rx_valid)
        begin
          if (i_rx_byte[7:1] == my_addr)
          begin
            st_nxt.ack = 1'b1;
            st_nxt.rd = i_rx_byte[0];
            if (i_rx_byte[0])
            begin
              st_nxt.regs[ADDR_DATA_LO] = pins_s[7:0];
              st_nxt.regs[ADDR_DATA_MID] = pins_s[15:8];
              st_nxt.regs[ADDR_DATA_HI] = {4'h0, pins_s[19:16]};
            end
          end
          else
          begin
            st_nxt.state = GX_WAIT;
          end
        end
        else if (i_ack_done && st_r.ack)
        begin
          st_nxt.ack = 1'b0;
          if (st_r.rd)
          begin
            st_nxt.tx = st_r.regs[st_r.ptr];
            st_nxt.ptr = ptr_inc(st_r.ptr);
            st_nxt.state = GX_READ;
          end
          else
          begin
            st_nxt.state = GX_REGADDR;
          end
        end
      end
      GX_REGADDR:
      begin
        if (i_rx_valid)
        begin
          st_nxt.ack = 1'b1;
          st_nxt.ptr = (i_rx_byte > {4'h0, ADDR_LAST}) ? ADDR_FIRST : i_rx_byte[3:0];
        end
        else if (i_ack_done)
        begin
          st_nxt.ack = 1'b0;
          st_nxt.state = GX_WRITE;
        end
      end
      GX_WRITE:
      begin
        if (i_rx_valid)
        begin
          st_nxt.ack = 1'b1;
          st_nxt.wdata = i_rx_byte;
          st_nxt.wpend = 1'b1;
        end
        else if (i_ack_done && st_r.wpend)
        begin
          // Commit only once the ack is over
          st_nxt.ack = 1'b0;
          st_nxt.wpend = 1'b0;
          st_nxt.regs[st_r.ptr] = st_r.wdata & wr_mask(st_r.ptr);
          st_nxt.ptr = ptr_inc(st_r.ptr);
        end
      end
      GX_READ:
      begin
        if (i_ack_done)
        begin
          if (i_master_ack)
          begin
            st_nxt.tx = st_r.regs[st_r.ptr];
            st_nxt.ptr = ptr_inc(st_r.ptr);
          end
          else
          begin
            st_nxt.state = GX_WAIT;
          end
        end
      end
      default:
      begin
        st_nxt.state = GX_IDLE;
      end
    endcase
    // Start or stop mid byte cancels whatever is in flight
    if (i_start)
    begin
      st_nxt.state = GX_SLAVE;
      st_nxt.ack = 1'b0;
      st_nxt.wpend = 1'b0;
    end
    else if (i_stop)
    begin
      st_nxt.state = GX_IDLE;
      st_nxt.ack = 1'b0;
      st_nxt.wpend = 1'b0;
    end
    if (!rst_pin_n_s)
    begin
      st_nxt.regs = REG_RESET;
      st_nxt.state = GX_IDLE;
      st_nxt.ptr = ADDR_FIRST;
      st_nxt.ack = 1'b0;
      st_nxt.wpend = 1'b0;
      st_nxt.irq = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r.state <= GX_IDLE;
      st_r.ptr <= ADDR_FIRST;
      st_r.rd <= 1'b0;
      st_r.ack <= 1'b0;
      st_r.wdata <= 8'h00;
      st_r.wpend <= 1'b0;
      st_r.tx <= 8'h00;
      st_r.pend_q <= 1'b0;
      st_r.irq <= 1'b0;
      st_r.regs <= REG_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Polarity applied in a flop so the pin never glitches
  logic irq_pin_r;
  logic irq_pin_nxt;
  assign irq_pin_nxt = st_r.irq ^ st_r.regs[ADDR_CTRL][CTRL_IRQ_POL];

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      irq_pin_r <= 1'b0;
    end
    else
    begin
      irq_pin_r <= irq_pin_nxt;
    end
  end

  gx_port_drive #(.WIDTH(PORTS), .LOW_WIDTH(LOW_PORTS)) u_drive (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_data(data_v),
    .i_dir(dir_v),
    .i_style_lo(st_r.regs[ADDR_CTRL][CTRL_STYLE_LO]),
    .i_style_hi(st_r.regs[ADDR_CTRL][CTRL_STYLE_HI]),
    .o_out(o_port_out),
    .o_oe(o_port_oe)
  );

  assign o_ack = st_r.ack;
  assign o_read_mode = st_r.rd;
  assign o_tx_byte = st_r.tx;
  assign o_irq = irq_pin_r;

  property p_reset_load;
    @(posedge i_clock) disable iff (i_sys_rst)
    !rst_pin_n_s |=> (st_r.regs == REG_RESET);
  endproperty
  a_reset_load: assert property (p_reset_load)
    else $error("registers not at initial values under reset pin");

  property p_regs_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
    (rst_pin_n_s && !i_ack_done && !i_rx_valid) |=> $stable(st_r.regs);
  endproperty
  a_regs_hold: assert property (p_regs_hold)
    else $error("register changed outside an acknowledge");

  property p_pullup_low;
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_r.regs[ADDR_CTRL][CTRL_STYLE_LO] && !data_v[0])
      |=> (o_port_oe[0] && !o_port_out[0]);
  endproperty
  a_pullup_low: assert property (p_pullup_low)
    else $error("pull-up mode port not driven low");

  property p_dir_out;
    @(posedge i_clock) disable iff (i_sys_rst)
    (!st_r.regs[ADDR_CTRL][CTRL_STYLE_HI] && !dir_v[PORTS-1])
      |=> (o_port_oe[PORTS-1] && (o_port_out[PORTS-1] == $past(data_v[PORTS-1])));
  endproperty
  a_dir_out: assert property (p_dir_out)
    else $error("output-mode port not driving its data bit");

  property p_addr_clip;
    @(posedge i_clock) disable iff (i_sys_rst)
    (rst_pin_n_s && !i_start && !i_stop && st_r.state == GX_REGADDR && i_rx_valid
      && i_rx_byte > {4'h0, ADDR_LAST}) |=> (st_r.ptr == ADDR_FIRST);
  endproperty
  a_addr_clip: assert property (p_addr_clip)
    else $error("out-of-range register address not forced to zero");

  property p_wrap;
    @(posedge i_clock) disable iff (i_sys_rst)
    (rst_pin_n_s && !i_start && !i_stop && st_r.state == GX_WRITE && !i_rx_valid
      && i_ack_done && st_r.wpend && st_r.ptr == ADDR_LAST) |=> (st_r.ptr == ADDR_FIRST);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap after last register");

  property p_high_zero;
    @(posedge i_clock) disable iff (i_sys_rst)
    1'b1 |-> (st_r.regs[ADDR_DATA_HI][7:4] == 4'h0);
  endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("upper nibble of top port register not zero");

  // Pin shows the level refreshed at the ack, two flops later
  property p_irq_level;
    @(posedge i_clock) disable iff (i_sys_rst)
    (rst_pin_n_s && i_ack_done)
      |=> ##1 (o_irq == ($past(pending, 2) ^ $past(st_r.regs[ADDR_CTRL][CTRL_IRQ_POL])));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt pin not refreshed at acknowledge");
endmodule

// *** bench/gx_master_model.sv ***
// Purpose: Byte-level 2-wire master in front of the expander core.
// Assumes: Engine strobes are one-cycle pulses on i_clock.
// Notes: A released byte line shows the inverse of the last byte.
`timescale 1ns/10ps
module gx_master_model
(
  input wire logic i_clock,
  input wire logic i_ack,
  input wire logic [7:0] i_tx_byte,
  output logic o_start,
  output logic o_stop,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_ack_done,
  output logic o_master_ack
);
  // Cycles a byte takes on the wire; raise it for a slow master
  int gap = 3;
  initial
  begin
    {o_start, o_stop, o_rx_valid, o_ack_done, o_master_ack} = '0;
    o_rx_byte = 8'hA5;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Start when stp is 0, stop otherwise
  task automatic cond(input logic stp);
    o_start = !stp;
    o_stop = stp;
    step(1);
    o_start = 1'b0;
    o_stop = 1'b0;
    step(1);
  endtask
  // Whole byte handed over, acknowledge left open
  task automatic put_hold(input logic [7:0] d, output logic ack);
    o_rx_byte = d;
    o_rx_valid = 1'b1;
    step(1);
    o_rx_valid = 1'b0;
    step(gap);
    ack = i_ack;
  endtask
  task automatic ack_end();
    o_ack_done = 1'b1;
    step(1);
    o_ack_done = 1'b0;
    o_rx_byte = ~o_rx_byte;
    step(1);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    put_hold(d, ack);
    ack_end();
  endtask
  task automatic get(input logic more, output logic [7:0] d, output logic steady);
    step(1);
    d = i_tx_byte;
    step(gap);
    steady = (i_tx_byte === d);
    o_master_ack = more;
    ack_end();
    o_master_ack = ~more;
  endtask
endmodule

// *** bench/twenty_bit_gpio_expander_core_test.sv ***
// Purpose: Self-checking bench for the expander core through its byte interface.
// Assumes: Acknowledge is judged a few cycles after each received byte.
// Notes: Pins carry pull-ups, so released ports read the external level.
`timescale 1ns/10ps
module twenty_bit_gpio_expander_core_test;
  import gx_pkg::*;
  logic i_clock, i_sys_rst, rst_pin_n, addr_sel, ack_seen, steady;
  logic start, stop, rx_valid, ack_done, master_ack, o_ack, o_read_mode, o_irq;
  logic [7:0] rx_byte, o_tx_byte, b;
  logic [PORTS-1:0] o_port_out, o_port_oe, ext_r, port_pin;
  int err_total = 0;
  int n_compared = 0;
  // Driven ports win over the external level
  assign port_pin = (o_port_oe & o_port_out) | (~o_port_oe & ext_r);
  gx_core gx_core_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_active_low_reset_pin_n(rst_pin_n), .i_addr_sel(addr_sel), .i_start(start),
    .i_stop(stop), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_ack_done(ack_done),
    .i_master_ack(master_ack), .i_port_in(port_pin), .o_ack(o_ack),
    .o_read_mode(o_read_mode), .o_tx_byte(o_tx_byte), .o_port_out(o_port_out),
    .o_port_oe(o_port_oe), .o_irq(o_irq));
  gx_master_model gx_master_model_inst (.i_clock(i_clock), .i_ack(o_ack),
    .i_tx_byte(o_tx_byte), .o_start(start), .o_stop(stop), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte), .o_ack_done(ack_done), .o_master_ack(master_ack));
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] d, input logic exp);
    gx_master_model_inst.put(d, ack_seen);
    check(ack_seen, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    gx_master_model_inst.cond(1'b0);
    put({SLAVE_ADDR_PIN_LO, 1'b0}, 1'b1);
    put(a, 1'b1);
    foreach (d[i]) put(d[i], 1'b1);
    gx_master_model_inst.cond(1'b1);
    gx_master_model_inst.step(3);
  endtask
  // Direct read skips the register address and goes on from the pointer
  task automatic rd(input logic [7:0] a, input logic [7:0] e[$], input logic direct);
    gx_master_model_inst.cond(1'b0);
    if (!direct)
    begin
      put({SLAVE_ADDR_PIN_LO, 1'b0}, 1'b1);
      put(a, 1'b1);
      gx_master_model_inst.cond(1'b0);
    end
    put({SLAVE_ADDR_PIN_LO, 1'b1}, 1'b1);
    foreach (e[i])
    begin
      gx_master_model_inst.get(i < e.size() - 1, b, steady);
      check(b, e[i]);
      check(steady, 1'b1);
    end
    gx_master_model_inst.cond(1'b1);
    gx_master_model_inst.step(3);
  endtask
  initial
  begin
    i_sys_rst = 1'b1;
    rst_pin_n = 1'b0;
    addr_sel = 1'b0;
    ext_r = '1;
    repeat (16) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    rst_pin_n = 1'b1;
    gx_master_model_inst.step(4);
    check(o_port_oe, 20'h00000);
    check(o_irq, 1'b0);
    rd(8'h00, '{8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h0F, 8'h03,
      8'hFF}, 1'b0);
    $display("test reset values done");
    wr(8'h09, '{8'h00});
    wr(8'h06, '{8'h00, 8'hFF, 8'h07});
    check(o_port_oe, 20'h800FF);
    gx_master_model_inst.cond(1'b0);
    put({SLAVE_ADDR_PIN_LO, 1'b0}, 1'b1);
    put(8'h00, 1'b1);
    gx_master_model_inst.put_hold(8'hA5, ack_seen);
    check(o_port_out[7:0], 8'hFF);
    gx_master_model_inst.ack_end();
    gx_master_model_inst.cond(1'b1);
    gx_master_model_inst.step(3);
    check(o_port_out[7:0], 8'hA5);
    $display("test direction mode done");
    wr(8'h09, '{8'h02});
    wr(8'h01, '{8'h3C});
    check(o_port_oe[15:8], 8'hC3);
    check(o_port_out[15:8] & 8'hC3, 8'h00);
    check(o_port_oe[7:0], 8'hFF);
    wr(8'h02, '{8'hF5});
    check(o_port_oe[19:16], 4'hA);
    wr(8'h05, '{8'hF3});
    rd(8'h00, '{8'hA5, 8'h3C, 8'h05, 8'h00, 8'h00, 8'h03}, 1'b0);
    $display("test pull-up mode done");
    wr(8'h09, '{8'h03, 8'h0F});
    check(o_port_oe[7:0], 8'hF0);
    wr(8'h0C, '{8'h5A});
    check(o_port_oe[7:0], 8'hA5);
    // Stop in mid-data, then start followed at once by stop
    gx_master_model_inst.cond(1'b0);
    put({SLAVE_ADDR_PIN_LO, 1'b0}, 1'b1);
    put(8'h00, 1'b1);
    gx_master_model_inst.put_hold(8'hFF, ack_seen);
    check(ack_seen, 1'b1);
    gx_master_model_inst.cond(1'b1);
    gx_master_model_inst.cond(1'b0);
    gx_master_model_inst.cond(1'b1);
    check(o_port_oe[7:0], 8'hA5);
    $display("test addressing done");
    wr(8'h05, '{8'h01});
    rd(8'h00, '{8'h5A, 8'h3C, 8'h05}, 1'b0);
    check(o_irq, 1'b0);
    ext_r[16] = 1'b0;
    wr(8'h03, '{8'h00});
    check(o_irq, 1'b0);
    ext_r[18] = 1'b0;
    wr(8'h03, '{8'h00});
    check(o_irq, 1'b1);
    wr(8'h09, '{8'h07});
    check(o_irq, 1'b0);
    rd(8'h00, '{8'h5A, 8'h3C, 8'h00, 8'h00, 8'h00}, 1'b0);
    check(o_irq, 1'b1);
    rd(8'h00, '{8'h01}, 1'b1);
    $display("test interrupt done");
    for (int s = 0; s < 4; s++)
    begin
      addr_sel = s[1];
      gx_master_model_inst.cond(1'b0);
      put({s[0] ? SLAVE_ADDR_PIN_HI : SLAVE_ADDR_PIN_LO, 1'b0}, s[0] == s[1]);
      gx_master_model_inst.cond(1'b1);
    end
    addr_sel = 1'b0;
    rst_pin_n = 1'b0;
    gx_master_model_inst.step(2);
    rst_pin_n = 1'b1;
    gx_master_model_inst.step(3);
    check(o_port_oe, 20'h00000);
    rd(8'h09, '{8'h03}, 1'b0);
    $display("test slave address and reset pin done");
    // All ports as inputs, so every pin level reaches the capture
    wr(8'h09, '{8'h00});
    ext_r = 20'hA5C3E;
    rd(8'h00, '{8'h3E, 8'h5C, 8'h0A}, 1'b0);
    ext_r = 20'h5A3C1;
    rd(8'h00, '{8'hC1, 8'hA3, 8'h05}, 1'b0);
    $display("test pin capture done");
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    end_sim();
  end
endmodule
